/* hw/drp_ref_profile_regs.sv */
// Per-reference profile register bank for the second digital loop.
//
// The implementer's own choice: the strobed register port.
`include "drp_consts.svh"
`default_nettype none

// How it works
// - A two-bit priority field at bits 2:1 gives level 0 (highest) to 3 for this reference.
// - The loop may lock to this reference only while the enable bit 0 is 1, reset 0.
// - A 16-bit bandwidth factor over two bytes in 0.1 Hz steps resets to 500, that is 50 Hz.
// - Filter select bit 1 picks the normal 70 degree base filter at 0 and high margin at 1.
// - A 17-bit integer divider over three bytes holds ratio minus one, reset 0x007CB.
// - A 23-bit fraction numerator over three bytes, top byte bits 6:0, resets to 4.
// - A 23-bit fraction modulus over three bytes, top byte bits 6:0, resets to 5.
module drp_ref_profile_regs
  import drp_pkg::*;
#(
  parameter int INT_W = 17,
  parameter int FRAC_W = 23,
  parameter int BW_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`DRP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic ref_enable,
  output drp_prio_t ref_priority,
  output logic [BW_W-1:0] loop_bw_scale,
  output drp_filt_t loop_filter_select,
  output logic [INT_W-1:0] integer_divide_ratio_m1,
  output logic [INT_W:0] integer_divide_ratio,
  output logic [FRAC_W-1:0] fraction_numerator,
  output logic [FRAC_W-1:0] fraction_modulus,
  output logic fraction_valid
);
  // ************************************************************
  // Parameter check
  // ************************************************************
  if (INT_W != 17 || FRAC_W != 23 || BW_W != 16) begin : g_bad_width
    $error("drp_ref_profile_regs: byte layout serves only 17, 23 and 16 bits");
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  localparam int NREG = 13;
  logic [NREG-1:0] sel;
  logic [7:0] q [NREG];
  logic hit;

  always_comb begin
    sel = '0;
    case (reg_addr)
      `DRP_OFS_PRIO_EN: sel[0] = 1'b1;
      `DRP_OFS_BW_LO: sel[1] = 1'b1;
      `DRP_OFS_BW_HI: sel[2] = 1'b1;
      `DRP_OFS_FILT: sel[3] = 1'b1;
      `DRP_OFS_INT_LO: sel[4] = 1'b1;
      `DRP_OFS_INT_MID: sel[5] = 1'b1;
      `DRP_OFS_INT_TOP: sel[6] = 1'b1;
      `DRP_OFS_NUM_LO: sel[7] = 1'b1;
      `DRP_OFS_NUM_MID: sel[8] = 1'b1;
      `DRP_OFS_NUM_TOP: sel[9] = 1'b1;
      `DRP_OFS_MOD_LO: sel[10] = 1'b1;
      `DRP_OFS_MOD_MID: sel[11] = 1'b1;
      `DRP_OFS_MOD_TOP: sel[12] = 1'b1;
      default: sel = '0;
    endcase
    hit = |sel;
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  localparam logic [7:0] RSTV [NREG] = '{
    `DRP_RST_PRIO_EN, `DRP_RST_BW_LO, `DRP_RST_BW_HI, `DRP_RST_FILT,
    `DRP_RST_INT_LO, `DRP_RST_INT_MID, `DRP_RST_INT_TOP,
    `DRP_RST_NUM_LO, `DRP_RST_NUM_MID, `DRP_RST_NUM_TOP,
    `DRP_RST_MOD_LO, `DRP_RST_MOD_MID, `DRP_RST_MOD_TOP};
  localparam logic [7:0] MASKV [NREG] = '{
    `DRP_MASK_PRIO_EN, 8'hFF, 8'hFF, `DRP_MASK_FILT,
    8'hFF, 8'hFF, `DRP_MASK_INT_TOP,
    8'hFF, 8'hFF, `DRP_MASK_TOP7,
    8'hFF, 8'hFF, `DRP_MASK_TOP7};

  // Bank of byte registers, reserved bits held at zero.
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      drp_byte_reg #(
        .RST_VAL(RSTV[gi]),
        .MASK(MASKV[gi])
      ) u_reg (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(reg_wr && sel[gi]),
        .wr_data(reg_wdata),
        .q(q[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Read port
  // ************************************************************
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Unmapped addresses read as zero; data stands for one cycle only.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd && hit) begin
      for (int i = 0; i < NREG; i++) begin
        if (sel[i]) begin
          rdata_nxt = q[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ************************************************************
  // Settings toward the loop core
  // ************************************************************
  logic en_r;
  logic en_nxt;
  logic [1:0] prio_r;
  logic [1:0] prio_nxt;
  logic [BW_W-1:0] bw_r;
  logic [BW_W-1:0] bw_nxt;
  logic filt_r;
  logic filt_nxt;
  logic [INT_W-1:0] int_r;
  logic [INT_W-1:0] int_nxt;
  logic [FRAC_W-1:0] num_r;
  logic [FRAC_W-1:0] num_nxt;
  logic [FRAC_W-1:0] mod_r;
  logic [FRAC_W-1:0] mod_nxt;

  always_comb begin
    en_nxt = q[0][`DRP_ENABLE_BIT];
    prio_nxt = q[0][`DRP_PRIO_MSB:`DRP_PRIO_LSB];
    bw_nxt = {q[2], q[1]};
    filt_nxt = q[3][`DRP_FILT_BIT];
    int_nxt = {q[6][0], q[5], q[4]};
    num_nxt = {q[9][6:0], q[8], q[7]};
    mod_nxt = {q[12][6:0], q[11], q[10]};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'(`DRP_RST_PRIO_EN >> `DRP_ENABLE_BIT);
      prio_r <= 2'(`DRP_RST_PRIO_EN >> `DRP_PRIO_LSB);
      bw_r <= {`DRP_RST_BW_HI, `DRP_RST_BW_LO};
      filt_r <= 1'(`DRP_RST_FILT >> `DRP_FILT_BIT);
      int_r <= 17'({`DRP_RST_INT_TOP & `DRP_MASK_INT_TOP, `DRP_RST_INT_MID, `DRP_RST_INT_LO});
      num_r <= 23'({`DRP_RST_NUM_TOP & `DRP_MASK_TOP7, `DRP_RST_NUM_MID, `DRP_RST_NUM_LO});
      mod_r <= 23'({`DRP_RST_MOD_TOP & `DRP_MASK_TOP7, `DRP_RST_MOD_MID, `DRP_RST_MOD_LO});
    end else begin
      en_r <= en_nxt;
      prio_r <= prio_nxt;
      bw_r <= bw_nxt;
      filt_r <= filt_nxt;
      int_r <= int_nxt;
      num_r <= num_nxt;
      mod_r <= mod_nxt;
    end
  end

  assign ref_enable = en_r;
  assign ref_priority = drp_prio_t'(prio_r);
  assign loop_bw_scale = bw_r;
  assign loop_filter_select = drp_filt_t'(filt_r);
  assign integer_divide_ratio_m1 = int_r;
  assign fraction_numerator = num_r;
  assign fraction_modulus = mod_r;

  // Divide ratio and fraction sanity for the feedback divider.
  drp_divider_ratio #(
    .INT_W(INT_W),
    .FRAC_W(FRAC_W)
  ) u_ratio (
    .clk(clk),
    .rst_n(rst_n),
    .int_minus_one(int_r),
    .numerator(num_r),
    .modulus(mod_r),
    .int_ratio(integer_divide_ratio),
    .frac_valid(fraction_valid)
  );
endmodule
`default_nettype wire

/* hw/drp_consts.svh */
// Offsets, field positions and reset values of the reference profile register bank.
`ifndef DRP_CONSTS_SVH
`define DRP_CONSTS_SVH

`define DRP_ADDR_W 16
`define DRP_OFS_PRIO_EN 16'h0567
`define DRP_OFS_BW_LO 16'h0568
`define DRP_OFS_BW_HI 16'h0569
`define DRP_OFS_FILT 16'h056A
`define DRP_OFS_INT_LO 16'h056B
`define DRP_OFS_INT_MID 16'h056C
`define DRP_OFS_INT_TOP 16'h056D
`define DRP_OFS_NUM_LO 16'h056E
`define DRP_OFS_NUM_MID 16'h056F
`define DRP_OFS_NUM_TOP 16'h0570
`define DRP_OFS_MOD_LO 16'h0571
`define DRP_OFS_MOD_MID 16'h0572
`define DRP_OFS_MOD_TOP 16'h0573

`define DRP_ENABLE_BIT 0
`define DRP_PRIO_LSB 1
`define DRP_PRIO_MSB 2
`define DRP_FILT_BIT 1

`define DRP_RST_PRIO_EN 8'h00
`define DRP_RST_BW_LO 8'hF4
`define DRP_RST_BW_HI 8'h01
`define DRP_RST_FILT 8'h00
`define DRP_RST_INT_LO 8'hCB
`define DRP_RST_INT_MID 8'h07
`define DRP_RST_INT_TOP 8'h00
`define DRP_RST_NUM_LO 8'h04
`define DRP_RST_NUM_MID 8'h00
`define DRP_RST_NUM_TOP 8'h00
`define DRP_RST_MOD_LO 8'h05
`define DRP_RST_MOD_MID 8'h00
`define DRP_RST_MOD_TOP 8'h00

`define DRP_MASK_PRIO_EN 8'h07
`define DRP_MASK_FILT 8'h02
`define DRP_MASK_INT_TOP 8'h01
`define DRP_MASK_TOP7 8'h7F

`endif

/* hw/drp_pkg.sv */
// Types shared by the reference profile register bank.
`default_nettype none
package drp_pkg;
  typedef enum logic [1:0] {
    DRP_PRIO_0 = 2'b00,
    DRP_PRIO_1 = 2'b01,
    DRP_PRIO_2 = 2'b10,
    DRP_PRIO_3 = 2'b11
  } drp_prio_t;
  typedef enum logic {
    DRP_FILT_NORMAL = 1'b0,
    DRP_FILT_HIGH = 1'b1
  } drp_filt_t;
endpackage
`default_nettype wire

/* hw/drp_byte_reg.sv */
// One byte-wide software register with write mask and reset value.
`default_nettype none
module drp_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;

  if ((RST_VAL & ~MASK) != 8'h00) begin : g_bad_reset
    $error("drp_byte_reg: reset value sets a reserved bit");
  end

  always_comb begin
    q_nxt = q_r;
    if (wr_en) begin
      q_nxt = wr_data & MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

/* hw/drp_divider_ratio.sv */
// Registered feedback divide ratio and fraction valid flag for the loop core.
`default_nettype none
module drp_divider_ratio #(
  parameter int INT_W = 17,
  parameter int FRAC_W = 23
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [INT_W-1:0] int_minus_one,
  input wire logic [FRAC_W-1:0] numerator,
  input wire logic [FRAC_W-1:0] modulus,
  output logic [INT_W:0] int_ratio,
  output logic frac_valid
);
  logic [INT_W:0] int_ratio_r;
  logic [INT_W:0] int_ratio_nxt;
  logic frac_valid_r;
  logic frac_valid_nxt;

  if (INT_W < 1 || FRAC_W < 1) begin : g_bad_width
    $error("drp_divider_ratio: widths must be positive");
  end

  always_comb begin
    int_ratio_nxt = {1'b0, int_minus_one} + {{INT_W{1'b0}}, 1'b1};
    frac_valid_nxt = (modulus != '0) && (numerator < modulus);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_ratio_r <= '0;
      frac_valid_r <= 1'b0;
    end else begin
      int_ratio_r <= int_ratio_nxt;
      frac_valid_r <= frac_valid_nxt;
    end
  end

  assign int_ratio = int_ratio_r;
  assign frac_valid = frac_valid_r;
endmodule
`default_nettype wire

/* tb/drp_regs_monitor.sv */
// Concurrent assertions on the ports of the reference profile register bank.
`include "drp_consts.svh"
`default_nettype none
module drp_regs_monitor
  import drp_pkg::*;
#(
  parameter int INT_W = 17,
  parameter int FRAC_W = 23,
  parameter int BW_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`DRP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ref_enable,
  input wire drp_prio_t ref_priority,
  input wire logic [BW_W-1:0] loop_bw_scale,
  input wire drp_filt_t loop_filter_select,
  input wire logic [INT_W-1:0] integer_divide_ratio_m1,
  input wire logic [INT_W:0] integer_divide_ratio,
  input wire logic [FRAC_W-1:0] fraction_numerator,
  input wire logic [FRAC_W-1:0] fraction_modulus,
  input wire logic fraction_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [15:0] a);
    reg_wr && reg_addr == a;
  endsequence
  property p_en;
    s_wr(`DRP_OFS_PRIO_EN) |-> ##2 ref_enable == $past(reg_wdata[0], 2);
  endproperty
  a_en: assert property (p_en) else $error("enable bit mismatch");
  property p_pri;
    s_wr(`DRP_OFS_PRIO_EN) |-> ##2 ref_priority == $past(reg_wdata[2:1], 2);
  endproperty
  a_pri: assert property (p_pri) else $error("priority mismatch");
  property p_bw;
    s_wr(`DRP_OFS_BW_LO) |-> ##2 loop_bw_scale[7:0] == $past(reg_wdata, 2);
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth mismatch");
  property p_flt;
    s_wr(`DRP_OFS_FILT) |-> ##2 loop_filter_select == $past(reg_wdata[1], 2);
  endproperty
  a_flt: assert property (p_flt) else $error("filter select mismatch");
  property p_int;
    s_wr(`DRP_OFS_INT_TOP) |-> ##2 integer_divide_ratio_m1[16] == $past(reg_wdata[0], 2);
  endproperty
  a_int: assert property (p_int) else $error("divider bit 16 mismatch");
  property p_num;
    s_wr(`DRP_OFS_NUM_TOP) |-> ##2 fraction_numerator[22:16] == $past(reg_wdata[6:0], 2);
  endproperty
  a_num: assert property (p_num) else $error("numerator mismatch");
  property p_mod;
    s_wr(`DRP_OFS_MOD_LO) |-> ##2 fraction_modulus[7:0] == $past(reg_wdata, 2);
  endproperty
  a_mod: assert property (p_mod) else $error("modulus mismatch");
  property p_rat;
    $past(rst_n) |-> integer_divide_ratio == {1'b0, $past(integer_divide_ratio_m1)} + 1'b1;
  endproperty
  a_rat: assert property (p_rat) else $error("divide ratio mismatch");
  property p_val;
    $past(rst_n) |-> fraction_valid == ($past(fraction_modulus) != 0
      && $past(fraction_numerator) < $past(fraction_modulus));
  endproperty
  a_val: assert property (p_val) else $error("fraction valid mismatch");
endmodule
bind drp_ref_profile_regs drp_regs_monitor #(.INT_W(INT_W), .FRAC_W(FRAC_W), .BW_W(BW_W)) u_mon (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_enable(ref_enable), .ref_priority(ref_priority),
  .loop_bw_scale(loop_bw_scale), .loop_filter_select(loop_filter_select),
  .integer_divide_ratio_m1(integer_divide_ratio_m1), .integer_divide_ratio(integer_divide_ratio),
  .fraction_numerator(fraction_numerator), .fraction_modulus(fraction_modulus),
  .fraction_valid(fraction_valid));
`default_nettype wire

/* tb/test_drp_ref_profile_regs.sv */
// Self-checking bench for the reference profile register bank.
`default_nettype none
module test_drp_ref_profile_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pend = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] mdl [13];
  logic [7:0] rstv [13];
  logic [7:0] msk [13];
  logic [7:0] expq [$];
  logic ref_enable, loop_filter_select, fraction_valid;
  logic [1:0] ref_priority;
  logic [15:0] loop_bw_scale;
  logic [16:0] m1;
  logic [17:0] ratio;
  logic [22:0] num, modv;
  int n_fail = 0, comparisons = 0;
  drp_ref_profile_regs u_drp_ref_profile_regs (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_enable(ref_enable), .ref_priority(ref_priority), .loop_bw_scale(loop_bw_scale),
    .loop_filter_select(loop_filter_select), .integer_divide_ratio_m1(m1),
    .integer_divide_ratio(ratio), .fraction_numerator(num), .fraction_modulus(modv),
    .fraction_valid(fraction_valid));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data shows in the cycle after the strobe, so compare one edge late.
  always @(posedge clk) begin
    if (pend) chk(reg_rdata, expq.pop_front());
    else if (rst_n) chk(reg_rdata, 8'h00);
    pend <= reg_rd;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    if (a >= 16'h0567 && a <= 16'h0573) mdl[a - 16'h0567] = d & msk[a - 16'h0567];
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    expq.push_back((a >= 16'h0567 && a <= 16'h0573) ? mdl[a - 16'h0567] : 8'h00);
  endtask
  task automatic rdall;
    for (int a = 16'h0567; a <= 16'h0573; a++) rd(16'(a));
  endtask
  task automatic chk_out;
    logic [22:0] n, m;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (4) @(posedge clk);
    n = {mdl[9][6:0], mdl[8], mdl[7]};
    m = {mdl[12][6:0], mdl[11], mdl[10]};
    chk(ref_enable, mdl[0][0]);
    chk(ref_priority, mdl[0][2:1]);
    chk(loop_bw_scale, {mdl[2], mdl[1]});
    chk(loop_filter_select, mdl[3][1]);
    chk(m1, {mdl[6][0], mdl[5], mdl[4]});
    chk(ratio, {1'b0, mdl[6][0], mdl[5], mdl[4]} + 18'h1);
    chk(num, n);
    chk(modv, m);
    chk(fraction_valid, m != 0 && n < m);
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 13; i++) mdl[i] = rstv[i];
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    summarize;
  end
  initial begin
    void'($urandom(32'h1b51));
    rstv = '{8'h00, 8'hF4, 8'h01, 8'h00, 8'hCB, 8'h07, 8'h00, 8'h04, 8'h00, 8'h00, 8'h05,
      8'h00, 8'h00};
    msk = '{8'h07, 8'hFF, 8'hFF, 8'h02, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'h7F, 8'hFF,
      8'hFF, 8'h7F};
    do_reset;
    rdall;
    chk_out;
    chk(ratio, 18'd1996);
    chk(loop_bw_scale, 16'd500);
    for (int k = 0; k < 3; k++) begin
      for (int a = 16'h0567; a <= 16'h0573; a++)
        wr(16'(a), (a == 16'h0569) ? 8'($urandom_range(8'h4D, 8'h02)) : 8'($urandom));
      rdall;
      chk_out;
    end
    for (int p = 0; p < 4; p++) begin
      wr(16'h0567, 8'(p * 2 + (p & 1)));
      wr(16'h056A, 8'(p * 2));
      chk_out;
    end
    wr(16'h0568, 8'h20);
    wr(16'h0569, 8'h50);
    wr(16'h056A, 8'h02);
    chk_out;
    wr(16'h056E, 8'h05);
    wr(16'h056F, 8'h00);
    wr(16'h0570, 8'h80);
    wr(16'h0571, 8'h05);
    wr(16'h0572, 8'h00);
    wr(16'h0573, 8'h80);
    chk_out;
    wr(16'h056E, 8'h04);
    chk_out;
    wr(16'h0574, 8'hFF);
    wr(16'h0566, 8'hFF);
    rd(16'h0574);
    rd(16'h0566);
    rdall;
    chk_out;
    do_reset;
    rdall;
    chk_out;
    summarize;
  end
endmodule
`default_nettype wire
